//--- rtl/wdc_pkg.sv
// shared constants, register map and carrier types of the watchdog and wake-up controller
package wdc_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the 32-bit register bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_WDT_CTRL = 8'h00; // watchdog_control
  localparam logic [7:0] OFF_PWR_CTRL = 8'h04; // power_reset_control
  localparam logic [7:0] OFF_STATUS = 8'h08; // powerdown_flag, expiry_flag
  localparam logic [7:0] OFF_SYS_MODE = 8'h0c; // system_mode_register
  localparam logic [7:0] OFF_PA_WAKE = 8'h10; // porta_wake_enable
  localparam logic [7:0] OFF_WAKE_INFO = 8'h14; // oscillator readiness, mode, wake cause

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] WDT_CTRL_RST = 8'h53;
  localparam logic [4:0] EN_CODE_ON = 5'h0a;
  localparam logic [4:0] EN_CODE_OFF = 5'h15;
  localparam int PWR_KEEP_BIT = 7;
  localparam int PWR_LOW_VOLTAGE_RESET_FLAG_BIT = 2;
  localparam int PWR_LRF_BIT = 1;
  localparam int PWR_WRF_BIT = 0;
  localparam int STAT_PDF_BIT = 1;
  localparam int STAT_EXP_BIT = 0;
  localparam int MODE_IDLE_BIT = 0;
  localparam int MODE_SUB_BIT = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int PA_W = 8;
  localparam int IRQ_W = 8;
  localparam int WDT_W = 18;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int SRESET_NS = 1000;
  localparam int SRESET_CYC = (SRESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYC = 128;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_RUN, MODE_SLEEP, MODE_IDLE0, MODE_IDLE1, MODE_SETTLE
  } wdc_mode_e;

  typedef enum logic [2:0] {
    CAUSE_NONE, CAUSE_PORT, CAUSE_IRQ_RESUME, CAUSE_IRQ_SERVICE, CAUSE_EXPIRY
  } wdc_cause_e;

  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } wdc_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } wdc_axi_rsp_s;

  typedef struct packed {
    logic cpu_run;
    logic sysclk_on;
    logic subclk_on;
    logic high_osc_on;
    logic high_osc_ready;
    logic low_osc_on;
    logic low_osc_ready;
    logic periph_on_sub;
    logic resume_pulse;
    logic irq_service_pulse;
    logic pcsp_reset_pulse;
    logic full_reset_pulse;
  } wdc_pwr_s;

endpackage : wdc_pkg

//--- rtl/wdc_watchdog.sv
// watchdog timer with power-down entry, wake-up control and register slave
`timescale 1ns/10ps

// Operation
// - stop with idle and keep bits enters idle1
// - stop clears counter, watchdog keeps counting
// - stop sets powerdown_flag, clears expiry_flag
// - wake on porta edge, interrupt, overflow
// - porta wake resumes after stop
// - masked interrupt or full stack resumes, else interrupt response
// - flag pending before stop cannot wake
// - powerdown_flag cleared by reset, clear; set stop
// - halted overflow sets expiry, resets pc/sp only
// - running overflow gives full reset, sets expiry
// - counter on source clock, eight period codes
// - code 10101 disables, 01010 enables watchdog
// - illegal code resets after delay, sets flag
// - code reset flag cleared only by software
// - control resets to enabled, period 011
// - counter cleared by code reset, clear, stop
// - one settle counter, low after high
// - no instruction before high oscillator ready
// - peripherals follow system clock source change
// - sub clock runs in idle, else depending on watchdog enable
// - power control bits 6..3 read zero
// - stop with idle 0 enters sleep
// - running overflow leaves powerdown_flag unchanged
module wdc_watchdog
  import wdc_pkg::*;
#(
  parameter int SETTLE_COUNT = SETTLE_CYC,
  parameter int SRESET_COUNT = SRESET_CYC
) (
  input wire logic core_clk, // 20 MHz core clock
  input wire logic rst_n, // power-on reset, synchronous
  input wire logic clk_en, // freezes all state while low
  input wire wdc_axi_req_s axi_req, // register bus, master side
  output wdc_axi_rsp_s axi_rsp, // register bus, slave side
  input wire logic cpu_halt, // stop instruction executed
  input wire logic cpu_clear_watchdog_instruction, // clear-watchdog instruction executed
  input wire logic [IRQ_W-1:0] irq_req, // interrupt request flags
  input wire logic [IRQ_W-1:0] irq_enabled, // interrupt enables
  input wire logic stack_full, // cpu stack has no free level
  input wire logic [PA_W-1:0] porta_pins, // port A pin levels
  input wire logic wdt_src_clk, // low-speed watchdog source clock
  input wire logic lvr_event, // low voltage reset occurred
  input wire logic lvrc_event, // voltage code reset occurred
  output wdc_pwr_s pwr // clock, oscillator and cpu controls
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    wdc_axi_rsp_s rsp;
    wdc_pwr_s out;
    logic aw_full;
    logic [7:0] aw_addr;
    logic w_full;
    logic [7:0] w_data;
    logic w_lane0;
    logic [7:0] wdt_ctrl;
    logic keep;
    logic low_voltage_reset_flag;
    logic voltage_code_reset_flag;
    logic wdt_code_reset_flag;
    logic powerdown_flag;
    logic expf;
    logic idle_sel;
    logic use_sub;
    logic [PA_W-1:0] pa_wake;
    wdc_mode_e mode;
    wdc_cause_e cause;
    logic [IRQ_W-1:0] irq_mask;
    logic [PA_W-1:0] pa_s1;
    logic [PA_W-1:0] pa_s2;
    logic [PA_W-1:0] pa_prev;
    logic src_s1;
    logic src_s2;
    logic src_prev;
    logic clr_req;
    logic [WDT_W-1:0] wdt_cnt;
    logic srst_busy;
    logic [15:0] srst_cnt;
    logic [15:0] settle_cnt;
    logic lo_off;
    logic low_pend;
  } wdc_state_s;

  wdc_state_s s_ff;
  wdc_state_s nxt_s;

  if (SETTLE_COUNT < 1 || SETTLE_COUNT > 65535) begin : g_bad_settle
    $error("SETTLE_COUNT must lie in 1..65535");
  end
  if (SRESET_COUNT < 1 || SRESET_COUNT > 65535) begin : g_bad_sreset
    $error("SRESET_COUNT must lie in 1..65535");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [WDT_W-1:0] wdc_period_mask(input logic [2:0] sel);
    logic [WDT_W-1:0] m;
    m = '0;
    unique case (sel)
      3'h0: m = 18'h000ff;
      3'h1: m = 18'h003ff;
      3'h2: m = 18'h00fff;
      3'h3: m = 18'h03fff;
      3'h4: m = 18'h07fff;
      3'h5: m = 18'h0ffff;
      3'h6: m = 18'h1ffff;
      3'h7: m = 18'h3ffff;
    endcase
    return m;
  endfunction : wdc_period_mask

  function automatic logic wdc_mapped(input logic [7:0] addr);
    return addr == OFF_WDT_CTRL || addr == OFF_PWR_CTRL || addr == OFF_STATUS ||
           addr == OFF_SYS_MODE || addr == OFF_PA_WAKE || addr == OFF_WAKE_INFO;
  endfunction : wdc_mapped

  logic wdt_on;
  logic tick;
  logic [WDT_W-1:0] wdt_mask;
  logic ovf;
  logic halted;
  logic [PA_W-1:0] pa_fall;
  logic [IRQ_W-1:0] irq_new;
  logic wake;
  logic halt_take;
  logic srst_fire;
  logic wr_go;
  logic resume_now;
  logic [7:0] rd_byte;

  assign wdt_on = s_ff.wdt_ctrl[7:3] == EN_CODE_ON;
  // source clock is sampled, so the counter advances once per source rising edge
  assign tick = s_ff.src_s2 & ~s_ff.src_prev;
  assign wdt_mask = wdc_period_mask(s_ff.wdt_ctrl[2:0]);
  assign ovf = wdt_on & tick & ((s_ff.wdt_cnt & wdt_mask) == wdt_mask);
  assign halted = s_ff.mode inside {MODE_SLEEP, MODE_IDLE0, MODE_IDLE1};
  assign pa_fall = s_ff.pa_prev & ~s_ff.pa_s2 & s_ff.pa_wake;
  // requests already raised at the stop are masked out of the wake sources
  assign irq_new = irq_req & ~s_ff.irq_mask;
  assign wake = halted & (ovf | (|irq_new) | (|pa_fall));
  assign halt_take = cpu_halt & (s_ff.mode == MODE_RUN) & ~ovf;
  assign srst_fire = s_ff.srst_busy & (s_ff.srst_cnt == 16'h0);
  assign wr_go = s_ff.aw_full & s_ff.w_full & ~s_ff.rsp.bvalid;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_byte = 8'h00;
    unique case (axi_req.araddr)
      OFF_WDT_CTRL: rd_byte = s_ff.wdt_ctrl;
      OFF_PWR_CTRL: rd_byte = {s_ff.keep, 4'h0, s_ff.low_voltage_reset_flag, s_ff.voltage_code_reset_flag, s_ff.wdt_code_reset_flag};
      OFF_STATUS: rd_byte = {6'h00, s_ff.powerdown_flag, s_ff.expf};
      OFF_SYS_MODE: rd_byte = {6'h00, s_ff.use_sub, s_ff.idle_sel};
      OFF_PA_WAKE: rd_byte = s_ff.pa_wake;
      OFF_WAKE_INFO: rd_byte = {s_ff.out.high_osc_ready, s_ff.out.low_osc_ready,
                                s_ff.mode, s_ff.cause};
      default: rd_byte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    resume_now = 1'b0;
    nxt_s.out.resume_pulse = 1'b0;
    nxt_s.out.irq_service_pulse = 1'b0;
    nxt_s.out.pcsp_reset_pulse = 1'b0;
    nxt_s.out.full_reset_pulse = 1'b0;

    // pin synchronisers and edge history
    nxt_s.pa_s1 = porta_pins;
    nxt_s.pa_s2 = s_ff.pa_s1;
    nxt_s.pa_prev = s_ff.pa_s2;
    nxt_s.src_s1 = wdt_src_clk;
    nxt_s.src_s2 = s_ff.src_s1;
    nxt_s.src_prev = s_ff.src_s2;

    // the source clock arrives sampled on core_clk, so one register aligns the clears
    nxt_s.clr_req = cpu_clear_watchdog_instruction | halt_take;

    // bus: write address and data are taken in either order
    if (axi_req.awvalid && s_ff.rsp.awready) begin
      nxt_s.aw_full = 1'b1;
      nxt_s.aw_addr = axi_req.awaddr;
      nxt_s.rsp.awready = 1'b0;
    end
    if (axi_req.wvalid && s_ff.rsp.wready) begin
      nxt_s.w_full = 1'b1;
      nxt_s.w_data = axi_req.wdata[7:0];
      nxt_s.w_lane0 = axi_req.wstrb[0];
      nxt_s.rsp.wready = 1'b0;
    end
    if (s_ff.rsp.bvalid && axi_req.bready) begin
      nxt_s.rsp.bvalid = 1'b0;
      nxt_s.rsp.awready = 1'b1;
      nxt_s.rsp.wready = 1'b1;
    end
    if (wr_go) begin
      nxt_s.aw_full = 1'b0;
      nxt_s.w_full = 1'b0;
      nxt_s.rsp.bvalid = 1'b1;
      nxt_s.rsp.bresp = wdc_mapped(s_ff.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      if (s_ff.w_lane0) begin
        unique case (s_ff.aw_addr)
          OFF_WDT_CTRL: begin
            nxt_s.wdt_ctrl = s_ff.w_data;
            if (s_ff.w_data[7:3] != EN_CODE_ON && s_ff.w_data[7:3] != EN_CODE_OFF &&
                !s_ff.srst_busy) begin
              nxt_s.srst_busy = 1'b1;
              nxt_s.srst_cnt = 16'(SRESET_COUNT - 1);
            end
          end
          OFF_PWR_CTRL: begin
            nxt_s.keep = s_ff.w_data[PWR_KEEP_BIT];
            // flags clear on a written zero; a written one leaves them
            if (!s_ff.w_data[PWR_LOW_VOLTAGE_RESET_FLAG_BIT]) nxt_s.low_voltage_reset_flag = 1'b0;
            if (!s_ff.w_data[PWR_LRF_BIT]) nxt_s.voltage_code_reset_flag = 1'b0;
            if (!s_ff.w_data[PWR_WRF_BIT]) nxt_s.wdt_code_reset_flag = 1'b0;
          end
          OFF_SYS_MODE: begin
            nxt_s.idle_sel = s_ff.w_data[MODE_IDLE_BIT];
            nxt_s.use_sub = s_ff.w_data[MODE_SUB_BIT];
          end
          OFF_PA_WAKE: nxt_s.pa_wake = s_ff.w_data;
          default: ;
        endcase
      end
    end
    if (axi_req.arvalid && s_ff.rsp.arready) begin
      nxt_s.rsp.arready = 1'b0;
      nxt_s.rsp.rvalid = 1'b1;
      nxt_s.rsp.rdata = {24'h000000, rd_byte};
      nxt_s.rsp.rresp = wdc_mapped(axi_req.araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_ff.rsp.rvalid && axi_req.rready) begin
      nxt_s.rsp.rvalid = 1'b0;
      nxt_s.rsp.arready = 1'b1;
    end

    // illegal enable code: delayed reset, control restored so the reset cannot repeat
    if (s_ff.srst_busy && !srst_fire) nxt_s.srst_cnt = s_ff.srst_cnt - 16'h1;
    if (srst_fire) begin
      nxt_s.srst_busy = 1'b0;
      nxt_s.wdt_code_reset_flag = 1'b1;
      nxt_s.wdt_ctrl = WDT_CTRL_RST;
      nxt_s.out.full_reset_pulse = 1'b1;
    end
    // set wins over a clear written in the same cycle
    if (lvr_event) nxt_s.low_voltage_reset_flag = 1'b1;
    if (lvrc_event) nxt_s.voltage_code_reset_flag = 1'b1;
    if (cpu_clear_watchdog_instruction) nxt_s.powerdown_flag = 1'b0;

    // watchdog counter
    if (s_ff.clr_req || ovf || srst_fire) begin
      nxt_s.wdt_cnt = '0;
    end else if (wdt_on && tick) begin
      nxt_s.wdt_cnt = s_ff.wdt_cnt + 18'h1;
    end

    // power mode sequencer
    unique case (s_ff.mode)
      MODE_RUN: begin
        if (ovf) begin
          nxt_s.expf = 1'b1;
          nxt_s.out.full_reset_pulse = 1'b1;
        end else if (halt_take) begin
          nxt_s.powerdown_flag = 1'b1;
          nxt_s.expf = 1'b0;
          nxt_s.irq_mask = irq_req;
          nxt_s.cause = CAUSE_NONE;
          if (!s_ff.idle_sel) begin
            nxt_s.mode = MODE_SLEEP;
            nxt_s.lo_off = !wdt_on;
          end else if (s_ff.keep) begin
            nxt_s.mode = MODE_IDLE1;
          end else begin
            nxt_s.mode = MODE_IDLE0;
          end
        end
      end
      MODE_SLEEP, MODE_IDLE0, MODE_IDLE1: begin
        if (wake) begin
          if (ovf) begin
            nxt_s.cause = CAUSE_EXPIRY;
            nxt_s.expf = 1'b1;
          end else if (|irq_new) begin
            nxt_s.cause = (|(irq_new & irq_enabled) && !stack_full) ?
                          CAUSE_IRQ_SERVICE : CAUSE_IRQ_RESUME;
          end else begin
            nxt_s.cause = CAUSE_PORT;
          end
          if (s_ff.mode == MODE_SLEEP) begin
            nxt_s.mode = MODE_SETTLE;
            nxt_s.settle_cnt = 16'h0;
            nxt_s.low_pend = 1'b0;
          end else begin
            nxt_s.mode = MODE_RUN;
            resume_now = 1'b1;
          end
        end
      end
      MODE_SETTLE: begin
        if (s_ff.settle_cnt == 16'(SETTLE_COUNT - 1)) begin
          nxt_s.mode = MODE_RUN;
          resume_now = 1'b1;
          nxt_s.settle_cnt = 16'h0;
          // the low crystal only now gets the shared settle counter
          nxt_s.low_pend = s_ff.lo_off;
          nxt_s.lo_off = 1'b0;
        end else begin
          nxt_s.settle_cnt = s_ff.settle_cnt + 16'h1;
        end
      end
    endcase

    // low oscillator settle while running, on the same counter
    if (s_ff.mode == MODE_RUN && s_ff.low_pend) begin
      if (s_ff.settle_cnt == 16'(SETTLE_COUNT - 1)) begin
        nxt_s.low_pend = 1'b0;
        nxt_s.settle_cnt = 16'h0;
      end else begin
        nxt_s.settle_cnt = s_ff.settle_cnt + 16'h1;
      end
    end

    // wake outcome, presented once the cpu may run again
    if (resume_now) begin
      nxt_s.out.resume_pulse = nxt_s.cause inside {CAUSE_PORT, CAUSE_IRQ_RESUME};
      nxt_s.out.irq_service_pulse = nxt_s.cause == CAUSE_IRQ_SERVICE;
      nxt_s.out.pcsp_reset_pulse = nxt_s.cause == CAUSE_EXPIRY;
    end

    // clock and oscillator controls follow the next state
    nxt_s.out.cpu_run = nxt_s.mode == MODE_RUN;
    nxt_s.out.sysclk_on = nxt_s.mode inside {MODE_RUN, MODE_IDLE1};
    nxt_s.out.subclk_on = (nxt_s.wdt_ctrl[7:3] == EN_CODE_ON) ||
                          (nxt_s.mode inside {MODE_IDLE0, MODE_IDLE1});
    nxt_s.out.high_osc_on = nxt_s.mode != MODE_SLEEP;
    nxt_s.out.high_osc_ready = !(nxt_s.mode inside {MODE_SLEEP, MODE_SETTLE});
    nxt_s.out.low_osc_on = !nxt_s.lo_off;
    nxt_s.out.low_osc_ready = !nxt_s.lo_off && !nxt_s.low_pend;
    nxt_s.out.periph_on_sub = nxt_s.use_sub;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_ff <= '0;
      s_ff.rsp.awready <= 1'b1;
      s_ff.rsp.wready <= 1'b1;
      s_ff.rsp.arready <= 1'b1;
      s_ff.wdt_ctrl <= WDT_CTRL_RST;
      s_ff.low_pend <= 1'b1;
      s_ff.out.cpu_run <= 1'b1;
      s_ff.out.sysclk_on <= 1'b1;
      s_ff.out.subclk_on <= 1'b1;
      s_ff.out.high_osc_on <= 1'b1;
      s_ff.out.high_osc_ready <= 1'b1;
      s_ff.out.low_osc_on <= 1'b1;
    end else if (clk_en) begin
      s_ff <= nxt_s;
    end
  end

  assign axi_rsp = s_ff.rsp;
  assign pwr = s_ff.out;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  chk_halt_flags: assert property (
    clk_en && halt_take |=> s_ff.powerdown_flag && !s_ff.expf && !s_ff.out.cpu_run)
    else $error("stop did not set powerdown and clear expiry");

  chk_clear_pdf: assert property (
    clk_en && cpu_clear_watchdog_instruction && !halt_take |=> !s_ff.powerdown_flag)
    else $error("clear-watchdog left powerdown_flag set");

  chk_idle1_clocks: assert property (
    s_ff.mode == MODE_IDLE1 |-> s_ff.out.sysclk_on && s_ff.out.subclk_on && !s_ff.out.cpu_run)
    else $error("idle1 clocks wrong");

  chk_sleep_clocks: assert property (
    s_ff.mode == MODE_SLEEP |-> !s_ff.out.sysclk_on &&
      (s_ff.out.subclk_on == (s_ff.wdt_ctrl[7:3] == EN_CODE_ON)))
    else $error("sleep clocks wrong");

  chk_code_reset: assert property (
    clk_en && srst_fire |=> s_ff.out.full_reset_pulse && s_ff.wdt_code_reset_flag &&
      s_ff.wdt_ctrl == WDT_CTRL_RST && s_ff.wdt_cnt == '0)
    else $error("illegal code reset missing");

  chk_wrf_sticky: assert property (
    s_ff.wdt_code_reset_flag && !(clk_en && wr_go && s_ff.aw_addr == OFF_PWR_CTRL && s_ff.w_lane0 &&
      !s_ff.w_data[PWR_WRF_BIT]) |=> s_ff.wdt_code_reset_flag)
    else $error("code reset flag cleared without software");

  chk_counter_clear: assert property (
    clk_en && s_ff.clr_req |=> s_ff.wdt_cnt == '0)
    else $error("counter not cleared");

  chk_run_overflow: assert property (
    clk_en && ovf && s_ff.mode == MODE_RUN |=> s_ff.out.full_reset_pulse && s_ff.expf &&
      s_ff.powerdown_flag == $past(s_ff.powerdown_flag))
    else $error("running overflow response wrong");

  chk_halt_overflow: assert property (
    clk_en && ovf && halted |=> s_ff.expf && s_ff.powerdown_flag && !s_ff.out.full_reset_pulse)
    else $error("halted overflow response wrong");

  chk_pending_no_wake: assert property (
    clk_en && halted && irq_new == '0 && pa_fall == '0 && !ovf |=> s_ff.mode == $past(s_ff.mode))
    else $error("woke without a wake source");

  chk_port_resume: assert property (
    clk_en && s_ff.mode inside {MODE_IDLE0, MODE_IDLE1} && (|pa_fall) && irq_new == '0 && !ovf
      |=> s_ff.out.resume_pulse && s_ff.out.cpu_run)
    else $error("port wake did not resume");

  chk_ready_gates_run: assert property (
    s_ff.out.cpu_run |-> s_ff.out.high_osc_ready)
    else $error("cpu running before high oscillator ready");

  chk_low_after_high: assert property (
    s_ff.low_pend |-> s_ff.out.high_osc_ready && !s_ff.out.low_osc_ready)
    else $error("low settle overlaps high settle");

endmodule : wdc_watchdog

//--- tb/wdc_cpu_model.sv
// behavioural cpu core that issues the stop and clear-watchdog instructions
`timescale 1ns/10ps

module wdc_cpu_model
  import wdc_pkg::*;
(
  input wire logic core_clk, // core clock
  input wire logic rst_n, // synchronous reset
  input wire logic halt_cmd, // bench asks for a stop instruction
  input wire logic clr_cmd, // bench asks for a clear-watchdog instruction
  input wire wdc_pwr_s pwr, // power controls from the block
  output logic cpu_halt, // stop instruction pulse
  output logic cpu_clear_watchdog_instruction // clear-watchdog pulse
);
  // ----------------------------------------------------------------
  // instruction issue
  // ----------------------------------------------------------------
  // a halted core executes nothing, so both pulses are gated by cpu_run and a command given while halted is dropped
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cpu_halt <= 1'b0;
      cpu_clear_watchdog_instruction <= 1'b0;
    end else begin
      cpu_halt <= halt_cmd & pwr.cpu_run;
      cpu_clear_watchdog_instruction <= clr_cmd & pwr.cpu_run;
    end
  end
endmodule : wdc_cpu_model

//--- tb/tb_top.sv
// self-checking testbench of the watchdog and wake-up controller
`timescale 1ns/10ps

module tb_top
  import wdc_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic wdt_src_clk = 1'b0;
  logic src_run = 1'b0;
  logic halt_cmd = 1'b0;
  logic clr_cmd = 1'b0;
  logic cpu_halt;
  logic cpu_clear_watchdog_instruction;
  logic [IRQ_W-1:0] irq_req = '0;
  logic [IRQ_W-1:0] irq_en = '0;
  logic stack_full = 1'b0;
  logic [PA_W-1:0] porta = 8'hff;
  logic lvr_ev = 1'b0;
  logic lvrc_ev = 1'b0;
  wdc_axi_req_s req = '0;
  wdc_axi_rsp_s rsp;
  wdc_pwr_s pwr;
  int fail_count = 0;
  int tests_run = 0;
  logic [31:0] rd;
  logic [1:0] resp;

  always #25 core_clk = ~core_clk;
  // slow source clock, only toggled while a scenario needs ticks
  always #200 if (src_run) wdt_src_clk = ~wdt_src_clk;

  wdc_watchdog #(.SETTLE_COUNT(4), .SRESET_COUNT(2)) u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .axi_req(req), .axi_rsp(rsp),
    .cpu_halt(cpu_halt), .cpu_clear_watchdog_instruction(cpu_clear_watchdog_instruction), .irq_req(irq_req),
    .irq_enabled(irq_en), .stack_full(stack_full), .porta_pins(porta),
    .wdt_src_clk(wdt_src_clk), .lvr_event(lvr_ev), .lvrc_event(lvrc_ev), .pwr(pwr));

  wdc_cpu_model u_cpu (
    .core_clk(core_clk), .rst_n(rst_n), .halt_cmd(halt_cmd), .clr_cmd(clr_cmd),
    .pwr(pwr), .cpu_halt(cpu_halt), .cpu_clear_watchdog_instruction(cpu_clear_watchdog_instruction));

  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, n, lim);
      print_verdict();
    end
  endtask : bound

  // ----------------------------------------------------------------
  // register bus master
  // ----------------------------------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    req.awaddr <= a;
    req.awvalid <= 1'b1;
    req.wdata <= {24'h000000, d};
    req.wstrb <= 4'hf;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    n = 0;
    do begin @(posedge core_clk); n++; end while (!(rsp.awready && rsp.wready) && n < 50);
    bound(n, 50);
    req.awvalid <= 1'b0;
    req.wvalid <= 1'b0;
    n = 0;
    do begin @(posedge core_clk); n++; end while (!rsp.bvalid && n < 50);
    bound(n, 50);
    resp = rsp.bresp;
    req.bready <= 1'b0;
    @(posedge core_clk);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    int n;
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    n = 0;
    do begin @(posedge core_clk); n++; end while (!rsp.arready && n < 50);
    bound(n, 50);
    req.arvalid <= 1'b0;
    n = 0;
    do begin @(posedge core_clk); n++; end while (!rsp.rvalid && n < 50);
    bound(n, 50);
    rd = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
    @(posedge core_clk);
  endtask : axi_rd

  // waits for full_reset_pulse (rst_ev) or resume_pulse
  task automatic wait_ev(input bit rst_ev, input int lim);
    int n;
    n = 0;
    do begin @(posedge core_clk); n++; end
    while (!(rst_ev ? pwr.full_reset_pulse : pwr.resume_pulse) && n < lim);
    bound(n, lim);
  endtask : wait_ev

  task automatic cmd(input bit halt);
    if (halt) halt_cmd <= 1'b1;
    else clr_cmd <= 1'b1;
    @(posedge core_clk);
    halt_cmd <= 1'b0;
    clr_cmd <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : cmd

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic sc_reset_map();
    axi_rd(OFF_WDT_CTRL);
    cmp(rd, 32'h53);
    axi_rd(OFF_STATUS);
    cmp(rd, 32'h0);
    axi_rd(8'h3c);
    cmp(rd, 32'h0);
    cmp({30'h0, resp}, {30'h0, RESP_SLVERR});
  endtask : sc_reset_map

  task automatic sc_idle_port_wake();
    axi_wr(OFF_SYS_MODE, 8'h01);
    axi_wr(OFF_PWR_CTRL, 8'h80);
    axi_wr(OFF_PA_WAKE, 8'h01);
    cmd(1'b1);
    cmp({pwr.cpu_run, pwr.sysclk_on, pwr.subclk_on}, 32'h3);
    axi_rd(OFF_STATUS);
    cmp(rd, 32'h2);
    porta <= 8'hfe;
    wait_ev(1'b0, 20);
    @(posedge core_clk);
    cmp(pwr.cpu_run, 32'h1);
    porta <= 8'hff;
    axi_rd(OFF_WAKE_INFO);
    cmp(rd[2:0], CAUSE_PORT);
    cmd(1'b0);
    axi_rd(OFF_STATUS);
    cmp(rd, 32'h0);
  endtask : sc_idle_port_wake

  task automatic sc_illegal_code();
    axi_wr(OFF_WDT_CTRL, 8'h03);
    wait_ev(1'b1, 50);
    axi_rd(OFF_PWR_CTRL);
    cmp(rd, 32'h81);
    axi_rd(OFF_WDT_CTRL);
    cmp(rd, 32'h53);
    axi_wr(OFF_PWR_CTRL, 8'hfe);
    axi_rd(OFF_PWR_CTRL);
    cmp(rd, 32'h80);
    axi_wr(OFF_PWR_CTRL, 8'hff);
    axi_rd(OFF_PWR_CTRL);
    cmp(rd, 32'h80);
  endtask : sc_illegal_code

  task automatic sc_run_overflow();
    axi_wr(OFF_SYS_MODE, 8'h00);
    axi_wr(OFF_WDT_CTRL, {EN_CODE_ON, 3'b000});
    src_run = 1'b1;
    // 2^8 ticks of 8 core cycles each, plus margin
    wait_ev(1'b1, 2300);
    src_run = 1'b0;
    axi_rd(OFF_STATUS);
    cmp(rd, 32'h1);
  endtask : sc_run_overflow

  // a request raised before the stop must not wake; a new enabled one is serviced
  task automatic sc_sleep_irq_wake();
    int n;
    irq_req <= 8'h01;
    irq_en <= 8'h02;
    axi_wr(OFF_SYS_MODE, 8'h00);
    cmd(1'b1);
    cmp({pwr.cpu_run, pwr.sysclk_on, pwr.high_osc_ready}, 32'h0);
    repeat (8) @(posedge core_clk);
    cmp(pwr.cpu_run, 32'h0);
    irq_req <= 8'h03;
    n = 0;
    do begin @(posedge core_clk); n++; end while (!pwr.irq_service_pulse && n < 20);
    bound(n, 20);
    cmp({pwr.cpu_run, pwr.high_osc_ready}, 32'h3);
    irq_req <= 8'h00;
    irq_en <= 8'h00;
    axi_rd(OFF_WAKE_INFO);
    cmp(rd[2:0], CAUSE_IRQ_SERVICE);
  endtask : sc_sleep_irq_wake

  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    sc_reset_map();
    sc_idle_port_wake();
    sc_illegal_code();
    sc_run_overflow();
    sc_sleep_irq_wake();
    print_verdict();
  end
endmodule : tb_top
